// file: bsc_control_regs.sv
// control and configuration register bank of the barometric sensor
//
// Behaviour
// R1: a reboot request reloads trimming words from storage, then clears itself.
// R2: the reboot starts on the first conversion-rate tick after the request that finds no trimming load running.
// R3: trimming words load automatically right after power-up reset release.
// R4: fifo enable resets to zero; one enables the fifo.
// R5: halt-at-watermark resets to zero; one enables watermark level use.
// R6: address auto-increment resets to one and steers serial address advance.
// R7: serial bus disable resets to zero; one disables the i2c interface.
// R8: soft reset restores listed registers to defaults, then clears itself.
// R9: single shot in power-down runs one measurement, then self-clears.
// R10: host always writes zero to bit one of control_two.
// R11: polarity bit zero gives active-high pin, one gives active-low.
// R12: pad drive bit zero gives push-pull, one gives open-drain.
// R13: four enables, reset zero, gate full, watermark, overrun, data-ready.
// R14: source 00 carries data signals, priority data-ready, watermark, overrun, full.
// R15: source 01 pressure high, 10 pressure low, 11 either.
// R16: three-bit fifo mode resets to bypass and holds the eight codes.
// R17: fifo control low five bits hold the watermark level.
// R18: reference pressure is 24-bit, split low, mid, high at 15h-17h.
// R19: reference pressure is used only while auto-null or auto-reference is on.
// R20: pressure offset is 16-bit, low at 18h, high at 19h.
// R21: rate field 000 means power-down; configuration and interface stay alive.
// R22: after a single shot completes the device returns to power-down.
// R23: self-clearing bits read one while busy; writing zero never aborts.
// R24: pin is selected source, inverted if active-low; open-drain releases when idle.
`default_nettype none
module bsc_control_regs
	import bsc_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// register access from the serial engines
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// settings held elsewhere and conversion timing
	input wire logic [2:0] OUTPUT_RATE_SELECT,
	input wire logic AUTO_NULL_FUNCTION,
	input wire logic AUTO_REFERENCE_FUNCTION,
	input wire logic RATE_TICK,
	// measurement core handshake
	output logic CONV_START,
	input wire logic CONV_DONE,
	output logic POWER_DOWN,
	// configuration to fifo and serial engines
	output logic FIFO_ENABLE,
	output logic HALT_AT_WATERMARK,
	output bsc_pkg::bsc_fifo_mode_t FIFO_MODE,
	output logic [4:0] WATERMARK_LEVEL,
	output logic ADDR_AUTO_INC,
	output logic SERIAL_BUS_DISABLE,
	output logic SOFT_RESET_PULSE,
	// pressure references
	output logic [23:0] REFERENCE_PRESSURE,
	output logic REFERENCE_USE,
	output logic [15:0] PRESSURE_OFFSET,
	// interrupt sources and shared pin
	input wire logic DATA_READY,
	input wire logic FIFO_WATERMARK,
	input wire logic FIFO_OVERRUN,
	input wire logic FIFO_FULL,
	input wire logic PRESSURE_HIGH,
	input wire logic PRESSURE_LOW,
	output logic SHARED_IRQ_PIN_OUT,
	output logic SHARED_IRQ_PIN_OE,
	// trimming storage
	output logic [bsc_pkg::TRIM_AW-1:0] NVM_ADDR,
	input wire logic [7:0] NVM_RDATA,
	output logic [bsc_pkg::TRIM_WORDS*8-1:0] TRIM_VALUES,
	output logic BOOT_STATUS
);
	import bsc_pkg::*;

	// ==========================================
	// decoded write strobe for the self-clearing bits
	logic wr_ct2;

	assign wr_ct2 = REG_WR && (REG_ADDR == ADDR_CONTROL_TWO);

	// ==========================================
	// trimming loader
	logic load_start, load_busy, load_done;

	bsc_trim_loader u_loader (
		.clk(MCLK),
		.rst_n(RSTN),
		.start(load_start),
		.busy(load_busy),
		.done(load_done),
		.nvm_addr(NVM_ADDR),
		.nvm_rdata(NVM_RDATA),
		.trim_values(TRIM_VALUES)
	);

	// ==========================================
	// self-clearing operations: reboot, soft reset, single shot
	logic powerup_reg, powerup_next;
	logic boot_wait_reg, boot_wait_next;
	logic boot_run_reg, boot_run_next;
	logic swr_reg, swr_next;
	logic shot_reg, shot_next;
	logic conv_start_reg, conv_start_next;
	logic power_down_reg, power_down_next;
	logic rate_idle;

	assign rate_idle = (OUTPUT_RATE_SELECT == RATE_POWER_DOWN); // R21
	// a reboot waiting for its tick also waits out a running power-up load
	assign load_start = powerup_reg || (boot_wait_reg && RATE_TICK && !load_busy); // R2 R3

	always_comb begin
		powerup_next = 1'b0; // R3
		boot_wait_next = boot_wait_reg;
		boot_run_next = boot_run_reg;
		swr_next = 1'b0;
		shot_next = shot_reg;
		conv_start_next = 1'b0;
		// reboot: armed by a write of one, launched by the rate tick
		if (boot_wait_reg && RATE_TICK && !load_busy) begin
			boot_wait_next = 1'b0; // R2
			boot_run_next = 1'b1;
		end
		if (boot_run_reg && load_done) begin
			boot_run_next = 1'b0; // R1
		end
		if (wr_ct2 && REG_WDATA[CT2_REBOOT] && !boot_wait_reg && !boot_run_reg) begin
			boot_wait_next = 1'b1; // R1
		end
		// soft reset lives for exactly one cycle
		if (wr_ct2 && REG_WDATA[CT2_SOFT_RESET_REQUEST]) begin
			swr_next = 1'b1; // R8
		end
		// single shot: completion clears, a fresh accepted request wins
		if (shot_reg && CONV_DONE) begin
			shot_next = 1'b0; // R9 R22
		end
		if (wr_ct2 && REG_WDATA[CT2_SINGLE_SHOT] && rate_idle && !shot_next) begin
			shot_next = 1'b1; // R9
			conv_start_next = 1'b1;
		end
		power_down_next = rate_idle && !shot_next; // R21 R22
	end

	// writes of zero never reach these flags, so nothing running is aborted
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			powerup_reg <= 1'b1;
			boot_wait_reg <= 1'b0;
			boot_run_reg <= 1'b0;
			swr_reg <= 1'b0;
			shot_reg <= 1'b0;
			conv_start_reg <= 1'b0;
			power_down_reg <= 1'b1;
		end else begin
			powerup_reg <= powerup_next;
			boot_wait_reg <= boot_wait_next; // R23
			boot_run_reg <= boot_run_next;
			swr_reg <= swr_next;
			shot_reg <= shot_next; // R23
			conv_start_reg <= conv_start_next;
			power_down_reg <= power_down_next;
		end
	end

	// ==========================================
	// configuration storage
	logic [7:0] ct2_reg, ct2_next;
	logic [7:0] ipc_reg, ipc_next;
	logic [7:0] fctl_reg, fctl_next;
	logic [23:0] ref_reg, ref_next;
	logic [15:0] ofs_reg, ofs_next;

	// soft reset outranks a write landing in the same cycle
	always_comb begin
		ct2_next = ct2_reg;
		ipc_next = ipc_reg;
		fctl_next = fctl_reg;
		ref_next = ref_reg;
		ofs_next = ofs_reg;
		// bit one is not stored; it must be written as zero
		if (REG_WR) begin
			case (REG_ADDR)
				ADDR_CONTROL_TWO: ct2_next = REG_WDATA & CT2_CFG_MASK; // R4 R5 R6 R7 R10
				ADDR_INTERRUPT_PIN_CONTROL: ipc_next = REG_WDATA; // R11 R12 R13
				ADDR_FIFO_CONTROL: fctl_next = REG_WDATA; // R16 R17
				ADDR_REFERENCE_PRESSURE_LOW: ref_next[7:0] = REG_WDATA; // R18
				ADDR_REFERENCE_PRESSURE_MID: ref_next[15:8] = REG_WDATA; // R18
				ADDR_REFERENCE_PRESSURE_HIGH: ref_next[23:16] = REG_WDATA; // R18
				ADDR_PRESSURE_OFFSET_LOW: ofs_next[7:0] = REG_WDATA; // R20
				ADDR_PRESSURE_OFFSET_HIGH: ofs_next[15:8] = REG_WDATA; // R20
				default: ;
			endcase
		end
		if (swr_reg) begin
			ct2_next = CONTROL_TWO_RESET & CT2_CFG_MASK; // R8
			ipc_next = INTERRUPT_PIN_CONTROL_RESET;
			fctl_next = FIFO_CONTROL_RESET;
			ref_next = REFERENCE_PRESSURE_RESET;
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ct2_reg <= CONTROL_TWO_RESET & CT2_CFG_MASK; // R4 R5 R6 R7
			ipc_reg <= INTERRUPT_PIN_CONTROL_RESET; // R11 R12 R13
			fctl_reg <= FIFO_CONTROL_RESET; // R16
			ref_reg <= REFERENCE_PRESSURE_RESET;
			ofs_reg <= PRESSURE_OFFSET_RESET;
		end else begin
			ct2_reg <= ct2_next;
			ipc_reg <= ipc_next;
			fctl_reg <= fctl_next;
			ref_reg <= ref_next;
			ofs_reg <= ofs_next;
		end
	end

	// ==========================================
	// reference usage flag, registered like the other data outputs
	logic ref_use_reg, ref_use_next;

	always_comb begin
		ref_use_next = AUTO_NULL_FUNCTION || AUTO_REFERENCE_FUNCTION; // R19
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ref_use_reg <= 1'b0;
		end else begin
			ref_use_reg <= ref_use_next;
		end
	end

	// ==========================================
	// shared interrupt pin
	logic irq_out_reg, irq_out_next;
	logic irq_oe_reg, irq_oe_next;
	logic irq_level;

	// data mode picks the highest-priority enabled source, not an or of all
	always_comb begin
		irq_level = 1'b0;
		case (ipc_reg[IPC_SOURCE_MSB:IPC_SOURCE_LSB])
			SRC_DATA_SIGNAL: begin
				if (ipc_reg[IPC_DATA_READY_ROUTE_ENABLE]) begin
					irq_level = DATA_READY; // R13 R14
				end else if (ipc_reg[IPC_WATERMARK_ROUTE_ENABLE]) begin
					irq_level = FIFO_WATERMARK; // R13 R14
				end else if (ipc_reg[IPC_OVERRUN_ROUTE_ENABLE]) begin
					irq_level = FIFO_OVERRUN; // R13 R14
				end else if (ipc_reg[IPC_FULL_FLAG_ROUTE_ENABLE]) begin
					irq_level = FIFO_FULL; // R13 R14
				end
			end
			SRC_PRESSURE_HIGH: irq_level = PRESSURE_HIGH; // R15
			SRC_PRESSURE_LOW: irq_level = PRESSURE_LOW; // R15
			SRC_PRESSURE_EITHER: irq_level = PRESSURE_HIGH || PRESSURE_LOW; // R15
			default: irq_level = 1'b0;
		endcase
		irq_out_next = irq_level ^ ipc_reg[IPC_POLARITY_LOW]; // R11 R24
		irq_oe_next = !ipc_reg[IPC_PAD_DRIVE_SELECT] || irq_level; // R12 R24
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_out_reg <= 1'b0;
			irq_oe_reg <= 1'b1;
		end else begin
			irq_out_reg <= irq_out_next;
			irq_oe_reg <= irq_oe_next;
		end
	end

	// ==========================================
	// read-back, one cycle after the read strobe; unmapped reads zero
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] ct2_view;

	// self-clearing bits show one for as long as their operation runs
	assign ct2_view = ct2_reg
		| {(boot_wait_reg || boot_run_reg), 7'h00} // R23
		| {5'h00, swr_reg, 1'b0, shot_reg}; // R23

	always_comb begin
		rdata_next = rdata_reg;
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_CONTROL_TWO: rdata_next = ct2_view;
				ADDR_INTERRUPT_PIN_CONTROL: rdata_next = ipc_reg;
				ADDR_FIFO_CONTROL: rdata_next = fctl_reg;
				ADDR_REFERENCE_PRESSURE_LOW: rdata_next = ref_reg[7:0];
				ADDR_REFERENCE_PRESSURE_MID: rdata_next = ref_reg[15:8];
				ADDR_REFERENCE_PRESSURE_HIGH: rdata_next = ref_reg[23:16];
				ADDR_PRESSURE_OFFSET_LOW: rdata_next = ofs_reg[7:0];
				ADDR_PRESSURE_OFFSET_HIGH: rdata_next = ofs_reg[15:8];
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================
	// outputs
	assign REG_RDATA = rdata_reg;
	assign CONV_START = conv_start_reg; // R9
	assign POWER_DOWN = power_down_reg;
	assign FIFO_ENABLE = ct2_reg[CT2_FIFO_ENABLE]; // R4
	assign HALT_AT_WATERMARK = ct2_reg[CT2_HALT_AT_WATERMARK]; // R5
	assign ADDR_AUTO_INC = ct2_reg[CT2_ADDR_AUTO_INC]; // R6
	assign SERIAL_BUS_DISABLE = ct2_reg[CT2_SERIAL_BUS_DISABLE]; // R7
	assign FIFO_MODE = bsc_fifo_mode_t'(fctl_reg[FCTL_MODE_MSB:FCTL_MODE_LSB]); // R16
	assign WATERMARK_LEVEL = fctl_reg[FCTL_WATERMARK_MSB:FCTL_WATERMARK_LSB]; // R17
	assign SOFT_RESET_PULSE = swr_reg; // R8
	assign REFERENCE_PRESSURE = ref_reg;
	assign REFERENCE_USE = ref_use_reg; // R19
	assign PRESSURE_OFFSET = ofs_reg; // R20
	assign SHARED_IRQ_PIN_OUT = irq_out_reg;
	assign SHARED_IRQ_PIN_OE = irq_oe_reg;
	assign BOOT_STATUS = boot_wait_reg || boot_run_reg || load_busy;
endmodule
`default_nettype wire

// file: bsc_control_regs_properties.sv
// assertion checker for the control register bank
`default_nettype none
module bsc_control_regs_chk
	import bsc_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// conversion and boot
	input wire logic [2:0] OUTPUT_RATE_SELECT,
	input wire logic AUTO_NULL_FUNCTION,
	input wire logic AUTO_REFERENCE_FUNCTION,
	input wire logic CONV_START,
	input wire logic POWER_DOWN,
	input wire logic BOOT_STATUS,
	// configuration
	input wire logic SOFT_RESET_PULSE,
	input wire logic ADDR_AUTO_INC,
	input wire bsc_pkg::bsc_fifo_mode_t FIFO_MODE,
	input wire logic [4:0] WATERMARK_LEVEL,
	input wire logic [23:0] REFERENCE_PRESSURE,
	input wire logic REFERENCE_USE,
	// interrupt sources and pin
	input wire logic DATA_READY,
	input wire logic FIFO_WATERMARK,
	input wire logic FIFO_OVERRUN,
	input wire logic FIFO_FULL,
	input wire logic PRESSURE_HIGH,
	input wire logic PRESSURE_LOW,
	input wire logic SHARED_IRQ_PIN_OUT,
	input wire logic SHARED_IRQ_PIN_OE
);
	logic [7:0] ipc_reg, ipc_next;
	logic lvl, wr_ct2;
	// shadow of the pin control byte; soft reset beats a write in the same cycle
	always_comb begin
		ipc_next = ipc_reg;
		if (SOFT_RESET_PULSE) begin
			ipc_next = 8'h00;
		end else if (REG_WR && REG_ADDR == ADDR_INTERRUPT_PIN_CONTROL) begin
			ipc_next = REG_WDATA;
		end
	end
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ipc_reg <= 8'h00;
		end else begin
			ipc_reg <= ipc_next;
		end
	end
	// pin level before polarity: priority select, not an or of the data signals
	always_comb begin
		case (ipc_reg[1:0])
			2'h0: lvl = ipc_reg[2] ? DATA_READY : ipc_reg[4] ? FIFO_WATERMARK :
				ipc_reg[3] ? FIFO_OVERRUN : ipc_reg[5] & FIFO_FULL;
			2'h1: lvl = PRESSURE_HIGH;
			2'h2: lvl = PRESSURE_LOW;
			default: lvl = PRESSURE_HIGH | PRESSURE_LOW;
		endcase
	end
	assign wr_ct2 = REG_WR && REG_ADDR == ADDR_CONTROL_TWO;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	property p_shot_start;
		wr_ct2 && REG_WDATA[0] && !REG_WDATA[2] && OUTPUT_RATE_SELECT == RATE_POWER_DOWN && POWER_DOWN
			|=> CONV_START && !POWER_DOWN;
	endproperty
	a_shot_start: assert property (p_shot_start) else $error("single shot not started");
	property p_shot_refused;
		wr_ct2 && OUTPUT_RATE_SELECT != RATE_POWER_DOWN |=> !CONV_START;
	endproperty
	a_shot_refused: assert property (p_shot_refused) else $error("shot started outside power-down");
	property p_soft_reset;
		wr_ct2 && REG_WDATA[2] |=> SOFT_RESET_PULSE ##1 (ADDR_AUTO_INC && FIFO_MODE == FMODE_BYPASS
			&& WATERMARK_LEVEL == 5'h00 && REFERENCE_PRESSURE == 24'h000000);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register set");
	property p_fifo_write;
		REG_WR && REG_ADDR == ADDR_FIFO_CONTROL && !SOFT_RESET_PULSE
			|=> {FIFO_MODE, WATERMARK_LEVEL} == $past(REG_WDATA);
	endproperty
	a_fifo_write: assert property (p_fifo_write) else $error("fifo control fields wrong");
	property p_bit1_zero;
		REG_RD && REG_ADDR == ADDR_CONTROL_TWO |=> !REG_RDATA[1];
	endproperty
	a_bit1_zero: assert property (p_bit1_zero) else $error("control_two bit1 read as one");
	property p_irq_level;
		SHARED_IRQ_PIN_OUT == $past(lvl ^ ipc_reg[7]);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt pin level wrong");
	property p_irq_drive;
		SHARED_IRQ_PIN_OE == $past(!ipc_reg[6] || lvl);
	endproperty
	a_irq_drive: assert property (p_irq_drive) else $error("interrupt pad drive wrong");
	property p_ref_use;
		REFERENCE_USE == $past(AUTO_NULL_FUNCTION || AUTO_REFERENCE_FUNCTION);
	endproperty
	a_ref_use: assert property (p_ref_use) else $error("reference use flag wrong");
	property p_boot_hold;
		wr_ct2 && REG_WDATA[7] |=> BOOT_STATUS [*3];
	endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("reboot not flagged");
	c_shot: cover property (CONV_START);
	c_soft: cover property (SOFT_RESET_PULSE);
	c_boot: cover property (BOOT_STATUS ##1 !BOOT_STATUS);
endmodule
bind bsc_control_regs bsc_control_regs_chk i_chk (.*);
`default_nettype wire

// file: bsc_control_regs_tb.sv
// self-checking bench for the control register bank
`default_nettype none
module bsc_control_regs_tb import bsc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, RATE_TICK = 1'b0;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, NVM_RDATA;
	logic [2:0] OUTPUT_RATE_SELECT = 3'h0, NVM_ADDR;
	logic AUTO_NULL_FUNCTION = 1'b0, AUTO_REFERENCE_FUNCTION = 1'b0, DATA_READY = 1'b0;
	logic FIFO_WATERMARK = 1'b0, FIFO_OVERRUN = 1'b0, FIFO_FULL = 1'b0, PRESSURE_HIGH = 1'b0, PRESSURE_LOW = 1'b0;
	logic CONV_START, CONV_DONE, POWER_DOWN, FIFO_ENABLE, HALT_AT_WATERMARK, ADDR_AUTO_INC, SERIAL_BUS_DISABLE;
	logic SOFT_RESET_PULSE, REFERENCE_USE, SHARED_IRQ_PIN_OUT, SHARED_IRQ_PIN_OE, BOOT_STATUS;
	bsc_fifo_mode_t FIFO_MODE;
	logic [4:0] WATERMARK_LEVEL;
	logic [23:0] REFERENCE_PRESSURE;
	logic [15:0] PRESSURE_OFFSET;
	logic [63:0] TRIM_VALUES;
	int mismatches = 0, total_checks = 0;
	// pin cases: control byte, sources dr/wm/ovr/full/high/low, pin level, pad enable
	logic [15:0] tab [12] = '{16'h00f1, 16'h1441, 16'h1483, 16'h2013, 16'h0823, 16'h010b,
		16'h0209, 16'h0307, 16'h8109, 16'h4100, 16'hc102, 16'h410b};
	bsc_control_regs i_dut (.*);
	bsc_far_side #(.CONV_LAT(12)) i_far (.clk(MCLK), .rst_n(RSTN), .nvm_addr(NVM_ADDR),
		.nvm_rdata(NVM_RDATA), .conv_start(CONV_START), .conv_done(CONV_DONE));
	// 40 MHz clock
	initial begin
		forever #12.5 MCLK = ~MCLK;
	end
	task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// bus tasks return just after the sampling edge, once outputs have settled
	task automatic tick(int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge MCLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		tick(1);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
		@(posedge MCLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		tick(1);
		REG_RD <= 1'b0;
		chk(name, exp, REG_RDATA);
	endtask
	task automatic wait_boot();
		for (int i = 0; i < 40 && BOOT_STATUS !== 1'b0; i++) tick(1);
		chk("boot_status", 0, BOOT_STATUS);
		for (int i = 0; i < TRIM_WORDS; i++) chk("trim_word", 8'h5c + i, TRIM_VALUES[8*i +: 8]);
	endtask
	task automatic t_defaults();
		tick(2);
		wait_boot();
		rd(ADDR_CONTROL_TWO, 8'h10, "control_two");
		for (int a = 8'h12; a <= 8'h19; a++) rd(8'(a), 8'h00, "reg_default");
		$display("test defaults done");
	endtask
	task automatic t_regs();
		wr(ADDR_CONTROL_TWO, 8'h68);
		chk("ctl_bits", 4'hd, {FIFO_ENABLE, HALT_AT_WATERMARK, ADDR_AUTO_INC, SERIAL_BUS_DISABLE});
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_FIFO_CONTROL, {m[2:0], 5'h1f - m[4:0]});
			chk("fifo_mode", m, FIFO_MODE);
			chk("watermark", 31 - m, WATERMARK_LEVEL);
		end
		for (int a = 0; a < 5; a++) wr(8'(8'h15 + a), 8'(8'h81 + a));
		chk("ref_pressure", 24'h838281, REFERENCE_PRESSURE);
		chk("offset", 16'h8584, PRESSURE_OFFSET);
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h00, "unmapped");
		for (int k = 2; k >= 0; k--) begin
			{AUTO_NULL_FUNCTION, AUTO_REFERENCE_FUNCTION} <= 2'(k);
			tick(2);
			chk("ref_use", k != 0, REFERENCE_USE);
		end
		$display("test registers done");
	endtask
	task automatic t_soft();
		wr(ADDR_INTERRUPT_PIN_CONTROL, 8'h0c);
		wr(ADDR_CONTROL_TWO, 8'h6c);
		chk("soft_pulse", 1, SOFT_RESET_PULSE);
		tick(1);
		chk("soft_pulse", 0, SOFT_RESET_PULSE);
		chk("ctl_bits", 4'h2, {FIFO_ENABLE, HALT_AT_WATERMARK, ADDR_AUTO_INC, SERIAL_BUS_DISABLE});
		chk("fifo_ctl", 0, {FIFO_MODE, WATERMARK_LEVEL});
		chk("ref_pressure", 0, REFERENCE_PRESSURE);
		chk("offset_kept", 16'h8584, PRESSURE_OFFSET);
		rd(ADDR_INTERRUPT_PIN_CONTROL, 8'h00, "pin_ctl");
		$display("test soft reset done");
	endtask
	task automatic t_shot();
		wr(ADDR_CONTROL_TWO, 8'h11);
		chk("conv_start", 1, CONV_START);
		chk("power_down", 0, POWER_DOWN);
		wr(ADDR_CONTROL_TWO, 8'h10);
		rd(ADDR_CONTROL_TWO, 8'h11, "shot_busy");
		for (int i = 0; i < 30 && POWER_DOWN !== 1'b1; i++) tick(1);
		chk("power_down", 1, POWER_DOWN);
		rd(ADDR_CONTROL_TWO, 8'h10, "shot_clear");
		@(posedge MCLK);
		OUTPUT_RATE_SELECT <= 3'h1;
		wr(ADDR_CONTROL_TWO, 8'h11);
		chk("conv_start", 0, CONV_START);
		rd(ADDR_CONTROL_TWO, 8'h10, "shot_refused");
		OUTPUT_RATE_SELECT <= 3'h0;
		$display("test single shot done");
	endtask
	task automatic t_boot();
		wr(ADDR_CONTROL_TWO, 8'h90);
		tick(15);
		chk("boot_waits", 1, BOOT_STATUS);
		rd(ADDR_CONTROL_TWO, 8'h90, "boot_pending");
		RATE_TICK <= 1'b1;
		tick(1);
		RATE_TICK <= 1'b0;
		chk("nvm_addr", 0, NVM_ADDR);
		wait_boot();
		rd(ADDR_CONTROL_TWO, 8'h10, "boot_clear");
		$display("test reboot done");
	endtask
	task automatic t_irq();
		foreach (tab[i]) begin
			@(posedge MCLK);
			{DATA_READY, FIFO_WATERMARK, FIFO_OVERRUN, FIFO_FULL, PRESSURE_HIGH, PRESSURE_LOW} <= tab[i][7:2];
			wr(ADDR_INTERRUPT_PIN_CONTROL, tab[i][15:8]);
			tick(1);
			chk("irq_pin", tab[i][1:0], {SHARED_IRQ_PIN_OUT, SHARED_IRQ_PIN_OE});
		end
		$display("test interrupt pin done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge MCLK);
		RSTN <= 1'b1;
		t_defaults();
		t_regs();
		t_soft();
		t_shot();
		t_boot();
		t_irq();
		results();
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge MCLK);
		mismatches++;
		results();
	end
endmodule
`default_nettype wire

// file: bsc_far_side.sv
// model of the trimming storage and measurement core beside the bank
`default_nettype none
module bsc_far_side
	import bsc_pkg::*;
#(
	parameter int CONV_LAT = 12
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// trimming storage
	input wire logic [bsc_pkg::TRIM_AW-1:0] nvm_addr,
	output logic [7:0] nvm_rdata,
	// measurement core
	input wire logic conv_start,
	output logic conv_done
);
	int cnt;
	// word i is 8'h5c plus i, a cycle after its address; fixed conversion time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			conv_done <= 1'b0;
			nvm_rdata <= 8'h00;
		end else begin
			nvm_rdata <= 8'h5c + {5'h00, nvm_addr};
			conv_done <= cnt == 1;
			cnt <= conv_start ? CONV_LAT : (cnt != 0 ? cnt - 1 : 0);
		end
	end
endmodule
`default_nettype wire

// file: bsc_pkg.sv
// shared constants and types for the barometric sensor control register bank
`default_nettype none
package bsc_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h11;
	localparam logic [7:0] ADDR_INTERRUPT_PIN_CONTROL = 8'h12;
	localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h14;
	localparam logic [7:0] ADDR_REFERENCE_PRESSURE_LOW = 8'h15;
	localparam logic [7:0] ADDR_REFERENCE_PRESSURE_MID = 8'h16;
	localparam logic [7:0] ADDR_REFERENCE_PRESSURE_HIGH = 8'h17;
	localparam logic [7:0] ADDR_PRESSURE_OFFSET_LOW = 8'h18;
	localparam logic [7:0] ADDR_PRESSURE_OFFSET_HIGH = 8'h19;

	// ==========================================
	// control_two field positions
	localparam int CT2_REBOOT = 7;
	localparam int CT2_FIFO_ENABLE = 6;
	localparam int CT2_HALT_AT_WATERMARK = 5;
	localparam int CT2_ADDR_AUTO_INC = 4;
	localparam int CT2_SERIAL_BUS_DISABLE = 3;
	localparam int CT2_SOFT_RESET_REQUEST = 2;
	localparam int CT2_SINGLE_SHOT = 0;
	// bits of control_two held as plain configuration storage
	localparam logic [7:0] CT2_CFG_MASK = 8'h78;

	// ==========================================
	// interrupt_pin_control field positions
	localparam int IPC_POLARITY_LOW = 7;
	localparam int IPC_PAD_DRIVE_SELECT = 6;
	localparam int IPC_FULL_FLAG_ROUTE_ENABLE = 5;
	localparam int IPC_WATERMARK_ROUTE_ENABLE = 4;
	localparam int IPC_OVERRUN_ROUTE_ENABLE = 3;
	localparam int IPC_DATA_READY_ROUTE_ENABLE = 2;
	localparam int IPC_SOURCE_MSB = 1;
	localparam int IPC_SOURCE_LSB = 0;

	// ==========================================
	// fifo_control field positions
	localparam int FCTL_MODE_MSB = 7;
	localparam int FCTL_MODE_LSB = 5;
	localparam int FCTL_WATERMARK_MSB = 4;
	localparam int FCTL_WATERMARK_LSB = 0;

	// ==========================================
	// values after reset
	localparam logic [7:0] CONTROL_TWO_RESET = 8'h10;
	localparam logic [7:0] INTERRUPT_PIN_CONTROL_RESET = 8'h00;
	localparam logic [7:0] FIFO_CONTROL_RESET = 8'h00;
	localparam logic [23:0] REFERENCE_PRESSURE_RESET = 24'h000000;
	localparam logic [15:0] PRESSURE_OFFSET_RESET = 16'h0000;
	localparam logic [7:0] TRIM_WORD_RESET = 8'h00;

	// ==========================================
	// encodings
	localparam logic [2:0] RATE_POWER_DOWN = 3'h0;
	localparam logic [1:0] SRC_DATA_SIGNAL = 2'h0;
	localparam logic [1:0] SRC_PRESSURE_HIGH = 2'h1;
	localparam logic [1:0] SRC_PRESSURE_LOW = 2'h2;
	localparam logic [1:0] SRC_PRESSURE_EITHER = 2'h3;

	typedef enum logic [2:0] {
		FMODE_BYPASS = 3'h0,
		FMODE_FIFO = 3'h1,
		FMODE_STREAM = 3'h2,
		FMODE_STREAM_TO_FIFO = 3'h3,
		FMODE_BYPASS_TO_STREAM = 3'h4,
		FMODE_RESERVED = 3'h5,
		FMODE_DYNAMIC_STREAM = 3'h6,
		FMODE_BYPASS_TO_FIFO = 3'h7
	} bsc_fifo_mode_t;

	// ==========================================
	// trimming store geometry
	localparam int TRIM_WORDS = 8;
	localparam int TRIM_AW = 3;
	localparam logic [2:0] TRIM_LAST = 3'h7;

	typedef enum logic [2:0] {
		LOAD_IDLE = 3'b001,
		LOAD_FETCH = 3'b010,
		LOAD_DRAIN = 3'b100
	} bsc_load_state_t;
endpackage
`default_nettype wire

// file: bsc_trim_loader.sv
// trimming register store and its loader from nonvolatile storage
`default_nettype none
module bsc_trim_loader
	import bsc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	output logic busy,
	output logic done,
	// nonvolatile storage read port, data one cycle after address
	output logic [bsc_pkg::TRIM_AW-1:0] nvm_addr,
	input wire logic [7:0] nvm_rdata,
	// trimming values, word i in bits 8*i+7..8*i
	output logic [bsc_pkg::TRIM_WORDS*8-1:0] trim_values
);
	import bsc_pkg::*;

	// ==========================================
	// sequencer
	bsc_load_state_t state_reg, state_next;
	logic [TRIM_AW-1:0] addr_reg, addr_next;
	logic [TRIM_AW-1:0] cap_idx_reg, cap_idx_next;
	logic cap_valid_reg, cap_valid_next;
	logic done_reg, done_next;
	logic [7:0] trim_reg [TRIM_WORDS];

	// address walks every word; capture trails by the storage latency
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		cap_idx_next = cap_idx_reg;
		cap_valid_next = 1'b0;
		done_next = 1'b0;
		case (state_reg)
			LOAD_IDLE: begin
				if (start) begin
					state_next = LOAD_FETCH;
					addr_next = '0;
				end
			end
			LOAD_FETCH: begin
				cap_valid_next = 1'b1;
				cap_idx_next = addr_reg;
				if (addr_reg == TRIM_LAST) begin
					state_next = LOAD_DRAIN;
				end else begin
					addr_next = addr_reg + 3'h1;
				end
			end
			LOAD_DRAIN: begin
				state_next = LOAD_IDLE;
				done_next = 1'b1;
			end
			default: begin
				state_next = LOAD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= LOAD_IDLE;
			addr_reg <= '0;
			cap_idx_reg <= '0;
			cap_valid_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			cap_idx_reg <= cap_idx_next;
			cap_valid_reg <= cap_valid_next;
			done_reg <= done_next;
		end
	end

	// ==========================================
	// trimming words, one per entry
	for (genvar i = 0; i < TRIM_WORDS; i++) begin : g_trim
		logic [7:0] word_next;
		always_comb begin
			word_next = trim_reg[i];
			if (cap_valid_reg && (cap_idx_reg == TRIM_AW'(i))) begin
				word_next = nvm_rdata;
			end
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				trim_reg[i] <= TRIM_WORD_RESET;
			end else begin
				trim_reg[i] <= word_next;
			end
		end
		assign trim_values[8*i+7:8*i] = trim_reg[i];
	end

	assign busy = (state_reg != LOAD_IDLE);
	assign done = done_reg;
	assign nvm_addr = addr_reg;
endmodule
`default_nettype wire
